// [rtl/cvc_pkg.sv]
// package: constants, formats and bus carrier for the voice codec
`default_nettype none

package cvc_pkg;

  // ************
  // timing
  // ************
  localparam int unsigned CLK_HZ   = 125_000_000;
  localparam int unsigned TICK_HZ  = 64_000;
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int          TICK_W   = 11;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

  // ************
  // delta modulation
  // ************
  localparam int          ACC_DECAY_SH  = 5;
  localparam int          STEP_DECAY_SH = 10;
  localparam int          HIST_LEN      = 4;
  localparam int          STEP_FRAC     = 10;
  localparam int          STEP_W        = 21;
  localparam int          STEP_IW       = STEP_W - STEP_FRAC;
  // step sizes kept with STEP_FRAC fraction bits: 10 and 1280
  localparam logic [STEP_W-1:0] STEP_MIN = 21'h002800;
  localparam logic [STEP_W-1:0] STEP_MAX = 21'h140000;
  localparam logic signed [15:0] ACC_MAX = 16'sh7fff;
  localparam logic signed [15:0] ACC_MIN = 16'sh8001;

  // ************
  // log pcm
  // ************
  localparam logic [2:0]  PCM_LAST   = 3'h7;
  localparam logic [15:0] MU_BIAS    = 16'h0084;
  localparam logic [15:0] MU_CLIP    = 16'h7f7b;
  localparam int          MU_MANT_SH = 3;
  localparam int          MU_SEG_LSB = 7;
  localparam int          A_IN_SH    = 3;
  localparam int          A_SEG_LSB  = 5;
  localparam logic [7:0]  A_XOR_POS  = 8'hd5;
  localparam logic [7:0]  A_XOR_NEG  = 8'h55;
  localparam logic [15:0] A_HALF     = 16'h0008;
  localparam logic [15:0] A_OFS      = 16'h0108;
  localparam logic [7:0]  A_SILENCE  = 8'hd5;
  localparam logic [7:0]  MU_SILENCE = 8'hff;

  // ************
  // register map
  // ************
  localparam int              ADDR_W    = 5;
  localparam logic [ADDR_W-1:0] REG_CTRL  = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STAT  = 5'h04;
  localparam logic [ADDR_W-1:0] REG_ESTEP = 5'h08;
  localparam logic [ADDR_W-1:0] REG_EACC  = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_DSMP  = 5'h10;
  localparam int              CTRL_AIR_LSB  = 0;
  localparam int              CTRL_LINE_LSB = 2;

  typedef enum logic [1:0] {CVC_AIR_CVSD, CVC_AIR_ALAW, CVC_AIR_MULAW} cvc_air_fmt_t;
  typedef enum logic [1:0] {CVC_LINE_LIN, CVC_LINE_ALAW, CVC_LINE_MULAW} cvc_line_fmt_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
  } cvc_avs_req_t;

endpackage : cvc_pkg

`default_nettype wire

// [rtl/cvc_cvsd_step.sv]
// module: step size and accumulator update shared by encoder and decoder
`default_nettype none

module cvc_cvsd_step
  import cvc_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  // control
  input  wire logic                clr_i,
  input  wire logic                tick_i,
  input  wire logic                bit_i,
  // state
  output logic signed [15:0]       pred_o,
  output logic signed [15:0]       acc_o,
  output logic [STEP_IW-1:0]       step_o,
  output logic                     ovl_o
);

  logic [HIST_LEN-1:0] hist_r;
  logic [HIST_LEN-1:0] hist_nxt;
  logic [STEP_W-1:0]   step_r;
  logic [STEP_W-1:0]   step_nxt;
  logic signed [15:0]  acc_r;
  logic signed [15:0]  acc_nxt;
  logic signed [17:0]  yhat;
  logic                ovl_nxt;
  logic                ovl_r;

  // ************
  // next state
  // ************
  always_comb begin
    hist_nxt = {hist_r[HIST_LEN-2:0], bit_i};
    ovl_nxt  = (&hist_nxt) | ~(|hist_nxt);
    if (ovl_nxt) begin
      step_nxt = step_r + STEP_MIN;
      if (step_nxt > STEP_MAX) step_nxt = STEP_MAX;
    end else begin
      step_nxt = step_r - (step_r >> STEP_DECAY_SH);
      if (step_nxt < STEP_MIN) step_nxt = STEP_MIN;
    end
    // bit 1 stands for a negative difference, so the step is subtracted
    if (bit_i) yhat = 18'(pred_o) - 18'(step_nxt[STEP_W-1:STEP_FRAC]);
    else       yhat = 18'(pred_o) + 18'(step_nxt[STEP_W-1:STEP_FRAC]);
    if (yhat > 18'(ACC_MAX))      acc_nxt = ACC_MAX;
    else if (yhat < 18'(ACC_MIN)) acc_nxt = ACC_MIN;
    else                          acc_nxt = yhat[15:0];
  end

  // ************
  // state registers
  // ************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || clr_i) begin
      hist_r <= '0;
      step_r <= STEP_MIN;
      acc_r  <= '0;
      ovl_r  <= 1'b0;
    end else if (tick_i) begin
      hist_r <= hist_nxt;
      step_r <= step_nxt;
      acc_r  <= acc_nxt;
      ovl_r  <= ovl_nxt;
    end
  end

  assign pred_o = acc_r - (acc_r >>> ACC_DECAY_SH);
  assign acc_o  = acc_r;
  assign step_o = step_r[STEP_W-1:STEP_FRAC];
  assign ovl_o  = ovl_r;

endmodule : cvc_cvsd_step

`default_nettype wire

// [rtl/cvc_voice_codec.sv]
// module: voice codec between linear or log PCM line samples and the 64 kb/s air stream
//
// Function
// - air stream runs at 64 kb/s as A-law, mu-law or delta modulation.
// - translate 8-bit codes between A-law and mu-law when line and air laws differ.
// - log PCM compression and expansion follow the standard companding tables.
// - encoder takes one 16-bit sample and emits one bit per 64 kHz tick.
// - output bit is 1 when sample minus prediction is negative, else 0.
// - prediction is accumulator times one minus one thirty-second.
// - overload flag set when the last four output bits are all equal.
// - step grows by 10 up to 1280 on overload, else decays to floor 10.
// - accumulator is prediction plus signed step, saturated to 16-bit signed.
// - bit, step and accumulator are the encoder state, updated in that order.
// - full scale of the 16-bit linear interface stands for 3 dBm0.
// - discarded voice packets are replaced by fill data, not a gap.
// - uncorrectable protected payload bits are passed on as received.
`default_nettype none

module cvc_voice_codec
  import cvc_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  // register bus
  input  wire cvc_pkg::cvc_avs_req_t avs_req_i,
  output logic [31:0]              avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // line side
  input  wire logic signed [15:0]  line_sample_i,
  output logic signed [15:0]       line_sample_o,
  output logic                     line_strobe_o,
  // air side
  output logic                     air_tx_bit_o,
  output logic                     air_tx_strobe_o,
  input  wire logic                air_rx_bit_i,
  input  wire logic                air_rx_lost_i
);

  // ************
  // companding functions
  // ************
  function automatic logic [7:0] mu_enc(input logic signed [15:0] s);
    logic [15:0] m;
    logic [2:0]  e;
    logic [3:0]  mant;
    m = s[15] ? 16'(-s) : 16'(s);
    if (m > MU_CLIP) m = MU_CLIP;
    m = m + MU_BIAS;
    e = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (m[i+MU_SEG_LSB]) e = 3'(i);
    end
    mant = 4'(m >> (4'(e) + 4'(MU_MANT_SH)));
    return ~{s[15], e, mant};
  endfunction : mu_enc

  function automatic logic signed [15:0] mu_dec(input logic [7:0] c);
    logic [7:0]  u;
    logic [15:0] t;
    u = ~c;
    t = ((16'(u[3:0]) << MU_MANT_SH) + MU_BIAS) << u[6:4];
    return u[7] ? 16'(MU_BIAS - t) : 16'(t - MU_BIAS);
  endfunction : mu_dec

  function automatic logic [7:0] a_enc(input logic signed [15:0] s);
    logic [15:0] p;
    logic [2:0]  seg;
    logic [3:0]  mant;
    p = 16'(s >>> A_IN_SH);
    if (s[15]) p = ~p;
    seg = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (p[i+A_SEG_LSB]) seg = 3'(i + 1);
    end
    if (seg < 3'h2) mant = 4'(p >> 1);
    else            mant = 4'(p >> seg);
    return {1'b0, seg, mant} ^ (s[15] ? A_XOR_NEG : A_XOR_POS);
  endfunction : a_enc

  function automatic logic signed [15:0] a_dec(input logic [7:0] c);
    logic [7:0]  a;
    logic [15:0] t;
    a = c ^ A_XOR_NEG;
    t = {8'h00, a[3:0], 4'h0};
    if (a[6:4] == 3'h0) t = t + A_HALF;
    else                t = (t + A_OFS) << (a[6:4] - 3'h1);
    return a[7] ? t : 16'(-t);
  endfunction : a_dec

  function automatic logic [7:0] law_enc(input logic mu, input logic signed [15:0] s);
    return mu ? mu_enc(s) : a_enc(s);
  endfunction : law_enc

  function automatic logic signed [15:0] law_dec(input logic mu, input logic [7:0] c);
    return mu ? mu_dec(c) : a_dec(c);
  endfunction : law_dec

  // ************
  // sample tick
  // ************
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  // ************
  // configuration
  // ************
  cvc_air_fmt_t  air_fmt_r;
  cvc_line_fmt_t line_fmt_r;
  logic          fmt_clr_r;
  logic          wait_r;
  logic          wr_take;
  logic [1:0]    wr_air;
  logic [1:0]    wr_line;
  logic          air_ok;
  logic          line_ok;

  assign wr_take = avs_req_i.write && !wait_r && (avs_req_i.address == REG_CTRL);
  assign wr_air  = avs_req_i.writedata[CTRL_AIR_LSB +: 2];
  assign wr_line = avs_req_i.writedata[CTRL_LINE_LSB +: 2];
  assign air_ok  = (wr_air != 2'h3);
  assign line_ok = (wr_line != 2'h3);

  // an unused code leaves that field as it was
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      air_fmt_r  <= CVC_AIR_CVSD;
      line_fmt_r <= CVC_LINE_LIN;
    end else if (wr_take) begin
      if (air_ok)  air_fmt_r  <= cvc_air_fmt_t'(wr_air);
      if (line_ok) line_fmt_r <= cvc_line_fmt_t'(wr_line);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fmt_clr_r <= 1'b0;
    end else begin
      fmt_clr_r <= wr_take && ((air_ok && (wr_air != air_fmt_r))
                   || (line_ok && (wr_line != line_fmt_r)));
    end
  end

  // ************
  // encoder and decoder state
  // ************
  logic               is_cvsd;
  logic               air_mu;
  logic               line_mu;
  logic               same_law;
  logic               cvsd_tick;
  logic signed [15:0] line_lin;
  logic signed [16:0] enc_diff;
  logic               enc_bit;
  logic signed [15:0] enc_pred;
  logic signed [15:0] enc_acc;
  logic [STEP_IW-1:0] enc_step;
  logic               enc_ovl;
  logic signed [15:0] dec_pred;
  logic               dec_ovl;
  logic               rx_bit;
  logic               fill_tgl_r;
  logic               fill_r;

  assign is_cvsd   = (air_fmt_r == CVC_AIR_CVSD);
  assign air_mu    = (air_fmt_r == CVC_AIR_MULAW);
  assign line_mu   = (line_fmt_r == CVC_LINE_MULAW);
  assign same_law  = (air_mu == line_mu);
  assign cvsd_tick = tick_r && is_cvsd;

  // full scale of line_lin corresponds to 3 dBm0; no gain is applied anywhere
  assign line_lin = (line_fmt_r == CVC_LINE_LIN) ? line_sample_i
                    : law_dec(line_mu, line_sample_i[7:0]);
  assign enc_diff = 17'(line_lin) - 17'(enc_pred);
  assign enc_bit  = enc_diff[16];

  cvc_cvsd_step u_enc_step (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clr_i     (fmt_clr_r),
    .tick_i    (cvsd_tick),
    .bit_i     (enc_bit),
    .pred_o    (enc_pred),
    .acc_o     (enc_acc),
    .step_o    (enc_step),
    .ovl_o     (enc_ovl)
  );

  cvc_cvsd_step u_dec_step (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clr_i     (fmt_clr_r),
    .tick_i    (cvsd_tick),
    .bit_i     (rx_bit),
    .pred_o    (dec_pred),
    .acc_o     (),
    .step_o    (),
    .ovl_o     (dec_ovl)
  );

  // ************
  // log pcm framing
  // ************
  logic [2:0]  pcm_cnt_r;
  logic [7:0]  tx_sh_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  tx_code;
  logic [7:0]  rx_byte;
  logic [7:0]  sil_code;
  logic signed [15:0] rx_lin;
  logic signed [15:0] rx_line;

  assign tx_code  = same_law && (line_fmt_r != CVC_LINE_LIN) ? line_sample_i[7:0]
                    : law_enc(air_mu, line_lin);
  assign sil_code = air_mu ? MU_SILENCE : A_SILENCE;

  // a lost packet is replaced by silence codes, or by an alternating bit
  // pattern that lets the delta decoder decay towards zero
  always_comb begin
    if (!air_rx_lost_i) rx_bit = air_rx_bit_i;
    else if (is_cvsd)   rx_bit = fill_tgl_r;
    else                rx_bit = sil_code[PCM_LAST - pcm_cnt_r];
  end

  assign rx_byte = {rx_sh_r[6:0], rx_bit};
  assign rx_lin  = law_dec(air_mu, rx_byte);
  assign rx_line = (line_fmt_r == CVC_LINE_LIN) ? rx_lin
                   : same_law ? {8'h00, rx_byte}
                   : {8'h00, law_enc(line_mu, rx_lin)};

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || fmt_clr_r) begin
      pcm_cnt_r <= '0;
      tx_sh_r   <= '0;
      rx_sh_r   <= '0;
    end else if (tick_r && !is_cvsd) begin
      pcm_cnt_r <= pcm_cnt_r + 1'b1;
      rx_sh_r   <= rx_byte;
      if (pcm_cnt_r == '0) tx_sh_r <= {tx_code[6:0], 1'b0};
      else                 tx_sh_r <= tx_sh_r << 1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || fmt_clr_r) begin
      fill_tgl_r <= 1'b0;
      fill_r     <= 1'b0;
    end else if (tick_r) begin
      fill_r <= air_rx_lost_i;
      if (air_rx_lost_i) fill_tgl_r <= ~fill_tgl_r;
    end
  end

  // ************
  // air and line outputs
  // ************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      air_tx_bit_o    <= 1'b0;
      air_tx_strobe_o <= 1'b0;
    end else begin
      air_tx_strobe_o <= tick_r;
      if (tick_r) begin
        if (is_cvsd)              air_tx_bit_o <= enc_bit;
        else if (pcm_cnt_r == '0) air_tx_bit_o <= tx_code[7];
        else                      air_tx_bit_o <= tx_sh_r[7];
      end
    end
  end

  // pcm output is held for the eight ticks of one code
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      line_sample_o <= '0;
      line_strobe_o <= 1'b0;
    end else begin
      line_strobe_o <= tick_r;
      if (cvsd_tick) line_sample_o <= dec_pred;
      else if (tick_r && (pcm_cnt_r == PCM_LAST)) line_sample_o <= rx_line;
    end
  end

  // ************
  // register bus
  // ************
  logic [31:0] rd_mux;

  always_comb begin
    case (avs_req_i.address)
      REG_CTRL:  rd_mux = {28'h0, 2'(line_fmt_r), 2'(air_fmt_r)};
      REG_STAT:  rd_mux = {29'h0, fill_r, dec_ovl, enc_ovl};
      REG_ESTEP: rd_mux = {21'h0, enc_step};
      REG_EACC:  rd_mux = {{16{enc_acc[15]}}, enc_acc};
      REG_DSMP:  rd_mux = {{16{dec_pred[15]}}, dec_pred};
      default:   rd_mux = 32'h0;
    endcase
  end

  // every access waits exactly one cycle; read data is captured meanwhile
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wait_r         <= 1'b1;
      avs_readdata_o <= '0;
    end else if ((avs_req_i.read || avs_req_i.write) && wait_r) begin
      wait_r         <= 1'b0;
      avs_readdata_o <= avs_req_i.read ? rd_mux : 32'h0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  assign avs_waitrequest_o = wait_r;

endmodule : cvc_voice_codec

`default_nettype wire

// [test/cvc_voice_codec_assertions.sv]
// checker: port timing of the voice codec
`default_nettype none

module cvc_voice_codec_assertions
  import cvc_pkg::*;
(
  // clock and reset
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  // register bus
  input wire cvc_pkg::cvc_avs_req_t avs_req_i,
  input wire logic [31:0]           avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  // line side
  input wire logic signed [15:0]    line_sample_i,
  input wire logic signed [15:0]    line_sample_o,
  input wire logic                  line_strobe_o,
  // air side
  input wire logic                  air_tx_bit_o,
  input wire logic                  air_tx_strobe_o,
  input wire logic                  air_rx_bit_i,
  input wire logic                  air_rx_lost_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ************
  // helper logic
  // ************
  logic [11:0] gap_r;
  logic        seen_r;
  logic [3:0]  wr_sh_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || air_tx_strobe_o) begin
      gap_r <= 12'h000;
    end else begin
      gap_r <= gap_r + 12'h001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      seen_r <= 1'b0;
    end else if (air_tx_strobe_o) begin
      seen_r <= 1'b1;
    end
  end

  // a format write clears codec state but not the outputs; recent writes still excuse a change
  always_ff @(posedge sys_clk_i) begin
    wr_sh_r <= {wr_sh_r[2:0], avs_req_i.write && !avs_waitrequest_o};
  end

  // ************
  // properties
  // ************
  property p_strobe_gap;
    air_tx_strobe_o && seen_r |-> gap_r == 12'h7a0;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("tick spacing differs from 1953 clocks");
  property p_first_tick;
    !seen_r |-> gap_r <= 12'h7a2;
  endproperty
  a_first_tick: assert property (p_first_tick)
    else $error("first tick after reset is late");
  property p_strobe_pulse;
    air_tx_strobe_o |=> !air_tx_strobe_o;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("air strobe longer than one cycle");
  property p_line_strobe;
    air_tx_strobe_o |-> line_strobe_o ##1 !line_strobe_o;
  endproperty
  a_line_strobe: assert property (p_line_strobe)
    else $error("line strobe not aligned with air strobe");
  property p_tx_hold;
    $changed(air_tx_bit_o) |-> air_tx_strobe_o || (|wr_sh_r);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("air bit changed between ticks");
  property p_line_hold;
    $changed(line_sample_o) |-> line_strobe_o || (|wr_sh_r);
  endproperty
  a_line_hold: assert property (p_line_hold)
    else $error("line sample changed between ticks");
  property p_wait_one;
    (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer not after one wait cycle");
  property p_wait_cause;
    $fell(avs_waitrequest_o) |-> $past(avs_req_i.read || avs_req_i.write);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("bus answer without request");
  property p_wait_pulse;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low for more than one cycle");

  c_tx_one: cover property (air_tx_strobe_o && air_tx_bit_o);
  c_read: cover property (avs_req_i.read && !avs_waitrequest_o);
  c_write: cover property (avs_req_i.write && !avs_waitrequest_o);
  c_lost: cover property (air_rx_lost_i && line_strobe_o);
endmodule : cvc_voice_codec_assertions

bind cvc_voice_codec cvc_voice_codec_assertions u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_req_i(avs_req_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .line_sample_i(line_sample_i), .line_sample_o(line_sample_o),
  .line_strobe_o(line_strobe_o), .air_tx_bit_o(air_tx_bit_o), .air_tx_strobe_o(air_tx_strobe_o),
  .air_rx_bit_i(air_rx_bit_i), .air_rx_lost_i(air_rx_lost_i));

`default_nettype wire

// [test/cvc_air_partner.sv]
// partner: packet side that feeds received voice bits, one byte msb first
`default_nettype none

module cvc_air_partner (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // control from bench
  input  wire logic       load_i,
  input  wire logic [7:0] byte_i,
  // air side
  input  wire logic       tx_strobe_i,
  output logic            rx_bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] byte_r;
  logic [2:0] idx_r;

  // next bit shown right after each strobe, ready well before the next tick
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      byte_r <= 8'h00;
      idx_r  <= 3'h0;
    end else if (load_i) begin
      byte_r <= byte_i;
      idx_r  <= 3'h0;
    end else if (tx_strobe_i) begin
      idx_r <= idx_r + 3'h1;
    end
  end

  // bits handed on as carried, no correction attempted
  assign rx_bit_o = byte_r[3'h7 - idx_r];
endmodule : cvc_air_partner

`default_nettype wire

// [test/cvc_voice_codec_tb.sv]
// testbench: registers, delta modulation and log pcm paths of the voice codec
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

module cvc_voice_codec_tb
  import cvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WDOG = 90_000;
  logic               sys_clk_i;
  logic               rst_i;
  cvc_avs_req_t       avs_req;
  logic [31:0]        rdata;
  logic               wait_req;
  logic signed [15:0] line_in;
  logic signed [15:0] line_out;
  logic               line_stb;
  logic               tx_bit;
  logic               tx_stb;
  logic               rx_bit;
  logic               rx_lost;
  logic               p_load;
  logic [7:0]         p_byte;
  int                 err_count;
  int                 checks_done;

  cvc_voice_codec dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_req_i(avs_req), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .line_sample_i(line_in), .line_sample_o(line_out),
    .line_strobe_o(line_stb), .air_tx_bit_o(tx_bit), .air_tx_strobe_o(tx_stb),
    .air_rx_bit_i(rx_bit), .air_rx_lost_i(rx_lost));
  cvc_air_partner u_partner (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .load_i(p_load), .byte_i(p_byte),
    .tx_strobe_i(tx_stb), .rx_bit_o(rx_bit));

  // ************
  // shared tasks
  // ************
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // entered just after an edge; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_req <= '{read: ~wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge sys_clk_i);
    end while (wait_req !== 1'b0);
    q = rdata;
    avs_req <= '0;
    @(posedge sys_clk_i);
  endtask : bus

  // a missing tick is caught by the watchdog
  task automatic tick;
    do begin
      @(posedge sys_clk_i);
    end while (tx_stb !== 1'b1);
  endtask : tick

  // one full code period after a format write; returns the byte sent on air
  task automatic pcm(input logic [31:0] ctrl, input logic signed [15:0] lin, input logic [7:0] rxb,
                     input logic lost, output logic [7:0] txb);
    logic [31:0] q;
    bus(1'b1, REG_CTRL, ctrl, q);
    line_in <= lin;
    rx_lost <= lost;
    p_byte  <= rxb;
    p_load  <= 1'b1;
    @(posedge sys_clk_i);
    p_load <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      tick;
      txb = {txb[6:0], tx_bit};
    end
    rx_lost <= 1'b0;
  endtask : pcm

  // ************
  // scenarios
  // ************
  task automatic t_regs;
    logic [31:0] q;
    bus(1'b0, REG_ESTEP, '0, q);
    `CHK(q, 32'h0000000a)
    bus(1'b0, REG_EACC, '0, q);
    `CHK(q, 32'h00000000)
    bus(1'b1, REG_ESTEP, 32'h00000055, q);
    bus(1'b1, REG_CTRL, 32'h00000003, q);
    bus(1'b0, 5'h14, '0, q);
    `CHK(q, 32'h00000000)
    bus(1'b0, REG_ESTEP, '0, q);
    `CHK(q, 32'h0000000a)
    bus(1'b0, REG_CTRL, '0, q);
    `CHK(q, 32'h00000000)
    $display("test regs done");
  endtask : t_regs

  task automatic t_cvsd;
    logic [31:0] q;
    logic [31:0] step_e [4] = '{32'h6d, 32'h6d, 32'h6d, 32'h77};
    for (int k = 0; k < 10; k++) begin
      tick;
      `CHK(tx_bit, 1'b0)
    end
    `CHK(line_out > 16'sh0000, 1'b1)
    bus(1'b0, REG_ESTEP, '0, q);
    `CHK(q, 32'h0000006e)
    bus(1'b0, REG_STAT, '0, q);
    `CHK(q[0], 1'b1)
    line_in <= -16'sh4000;
    for (int k = 0; k < 4; k++) begin
      tick;
      `CHK(tx_bit, 1'b1)
      bus(1'b0, REG_ESTEP, '0, q);
      `CHK(q, step_e[k])
      bus(1'b0, REG_STAT, '0, q);
      `CHK(q[0], k == 3)
    end
    $display("test cvsd done");
  endtask : t_cvsd

  task automatic t_clear;
    logic [31:0] q;
    bus(1'b1, REG_CTRL, 32'h00000001, q);
    bus(1'b1, REG_CTRL, 32'h00000000, q);
    bus(1'b0, REG_ESTEP, '0, q);
    `CHK(q, 32'h0000000a)
    bus(1'b0, REG_EACC, '0, q);
    `CHK(q, 32'h00000000)
    // two lost ticks from the cleared state: fill bits 0 then 1 leave the decoder at 1
    rx_lost <= 1'b1;
    tick;
    tick;
    rx_lost <= 1'b0;
    bus(1'b0, REG_DSMP, '0, q);
    `CHK(q, 32'h00000001)
    bus(1'b0, REG_STAT, '0, q);
    `CHK(q, 32'h00000004)
    $display("test clear done");
  endtask : t_clear

  task automatic t_mulaw;
    logic [7:0] b;
    pcm(32'h2, 16'sh03e8, 8'hce, 1'b0, b);
    `CHK(b, 8'hce)
    `CHK(line_out, 16'sh03dc)
    $display("test mulaw done");
  endtask : t_mulaw

  task automatic t_xlaw;
    logic [7:0] b;
    pcm(32'h9, 16'sh00ce, 8'hfa, 1'b0, b);
    `CHK(b, 8'hfb)
    `CHK(line_out, 16'sh00ce)
    $display("test translate done");
  endtask : t_xlaw

  task automatic t_fill;
    logic [7:0] b;
    pcm(32'h5, 16'sh0012, 8'hfa, 1'b1, b);
    `CHK(b, 8'h12)
    `CHK(line_out, 16'sh00d5)
    $display("test fill done");
  endtask : t_fill

  // ************
  // run control
  // ************
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    rst_i = 1'b1;
    avs_req = '0;
    line_in = 16'sh4000;
    rx_lost = 1'b0;
    p_load = 1'b0;
    p_byte = 8'h00;
    err_count = 0;
    checks_done = 0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    t_regs;
    t_cvsd;
    t_clear;
    t_mulaw;
    t_xlaw;
    t_fill;
    results;
  end

  // about 40 ticks of 1953 clocks are needed
  initial begin
    repeat (WDOG) @(posedge sys_clk_i);
    err_count++;
    results;
  end
endmodule : cvc_voice_codec_tb

`default_nettype wire
